// ==== logic/nmar_map.svh ====
// Purpose: offsets, field positions, reset values and codes for the native max address block
// Assumes: AXI4-Lite word registers, byte addresses below
// Notes: included by bare name
`ifndef NMAR_MAP_SVH
`define NMAR_MAP_SVH
`define NMAR_OFF_COMMAND      8'h00
`define NMAR_OFF_DEVHEAD      8'h04
`define NMAR_OFF_DEVCTL       8'h08
`define NMAR_OFF_SECTOR       8'h0C
`define NMAR_OFF_CYL_LOW      8'h10
`define NMAR_OFF_CYL_HIGH     8'h14
`define NMAR_OFF_ERROR        8'h18
`define NMAR_OFF_STATUS       8'h1C
`define NMAR_OFF_NATIVE_LO    8'h20
`define NMAR_OFF_NATIVE_HI    8'h24
`define NMAR_OFF_GEOMETRY     8'h28
`define NMAR_OFF_CTRL         8'h2C
`define NMAR_OFF_INT_STATUS   8'h30
`define NMAR_OFF_INT_MASK     8'h34
`define NMAR_CMD_NATIVE       8'hF8
`define NMAR_CMD_NATIVE_EXT   8'h27
`define NMAR_LBA28_CLAMP      28'hFFFFFFF
`define NMAR_DH_LBA_BIT       6
`define NMAR_DC_UPPER_BIT     7
`define NMAR_ERR_ABORT_BIT    2
`define NMAR_ST_BUSY_BIT      7
`define NMAR_ST_READY_BIT     6
`define NMAR_ST_SEEK_BIT      4
`define NMAR_ST_ERR_BIT       0
`define NMAR_DH_RESET         8'hA0
`define NMAR_NATIVE_RESET     48'h000000000000
`define NMAR_GEOM_RESET       32'h00000000
`define NMAR_EXEC_CYCLES      2
`endif

// ==== logic/nmar_pkg.sv ====
// Purpose: shared types for the native max address block
// Assumes: nothing
// Notes: constants live in nmar_map.svh
package nmar_pkg;
   typedef enum logic [1:0] {NMAR_IDLE, NMAR_BUSY, NMAR_DONE} nmar_state_t;
   typedef enum logic [1:0] {NMAR_Q_NONE, NMAR_Q_28, NMAR_Q_48, NMAR_Q_BAD} nmar_query_t;
endpackage

// ==== logic/nmar_result_if.sv ====
// Purpose: carries the computed result from the query formatter to the top
// Assumes: single clock
// Notes: formatter drives, top samples
`timescale 1ns/1ps
interface nmar_result_if;
   logic [7:0] sector;
   logic [7:0] cyl_low;
   logic [7:0] cyl_high;
   logic [3:0] head;
   logic [7:0] sector_hi;
   logic [7:0] cyl_low_hi;
   logic [7:0] cyl_high_hi;
   modport src (output sector, cyl_low, cyl_high, head, sector_hi, cyl_low_hi, cyl_high_hi);
   modport dst (input  sector, cyl_low, cyl_high, head, sector_hi, cyl_low_hi, cyl_high_hi);
endinterface

// ==== logic/nmar_format.sv ====
// Purpose: maps native maximum address to task-file fields for both query forms
// Assumes: native values stable while a query completes
// Notes: purely combinational
`timescale 1ns/1ps
`include "nmar_map.svh"
module nmar_format (
   input  wire logic                 ext_form,
   input  wire logic                 lba_mode,
   input  wire logic [47:0]          native_lba,
   input  wire logic [7:0]           chs_sector,
   input  wire logic [15:0]          chs_cylinder,
   input  wire logic [3:0]           chs_head,
   nmar_result_if.src                res
);
   logic [27:0] lba28;

   // 28-bit form saturates when the native value needs upper bits
   assign lba28 = (|native_lba[47:28]) ? `NMAR_LBA28_CLAMP : native_lba[27:0];  // R2

   always_comb begin
      res.sector_hi   = native_lba[31:24];  // R8
      res.cyl_low_hi  = native_lba[39:32];  // R9
      res.cyl_high_hi = native_lba[47:40];  // R10
      if (ext_form) begin
         res.sector   = native_lba[7:0];  // R8
         res.cyl_low  = native_lba[15:8];  // R9
         res.cyl_high = native_lba[23:16];  // R10
         res.head     = 4'h0;
      end else if (lba_mode) begin
         res.sector   = lba28[7:0];  // R3
         res.cyl_low  = lba28[15:8];  // R4
         res.cyl_high = lba28[23:16];  // R4
         res.head     = lba28[27:24];  // R5
      end else begin
         res.sector   = chs_sector;  // R6
         res.cyl_low  = chs_cylinder[7:0];  // R6
         res.cyl_high = chs_cylinder[15:8];  // R6
         res.head     = chs_head;  // R6
      end
   end
endmodule // nmar_format

// ==== logic/nmar_top.sv ====
// Purpose: command handling for the native maximum address queries, behind AXI4-Lite
// Assumes: single clock clk at 100 MHz, async active-low reset rstn
// Notes: native geometry is written through registers; any host-set maximum never touches it
// Function
// [R1] 28-bit query returns native maximum, ignoring any host-set maximum
// [R2] 28-bit result clamps to 268,435,455 when native exceeds 28 bits
// [R3] lba mode: sector number holds native bits 0-7
// [R4] lba mode: cylinder low bits 8-15, cylinder high bits 16-23
// [R5] lba mode: head field holds bits 24-27
// [R6] chs mode: return native sector, cylinder and head numbers
// [R7] extended query returns native 48-bit maximum, ignoring host-set maximum
// [R8] extended: sector reads bits 7:0, or 31:24 with upper select
// [R9] extended: cylinder low reads 15:8, or 39:32 with upper select
// [R10] extended: cylinder high reads 23:16, or 47:40 with upper select
// [R11] failed query sets abort and error bits only, busy clear
`timescale 1ns/1ps
`include "nmar_map.svh"
module nmar_top (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq
);
   // write channel capture
   logic        aw_held;
   logic [7:0]  aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_fire;
   logic        rd_fire;
   logic [7:0]  rd_addr;

   // task-file and configuration state
   logic [7:0]  dev_head;
   logic        upper_half_select;
   logic [7:0]  tf_sector;
   logic [7:0]  tf_cyl_low;
   logic [7:0]  tf_cyl_high;
   logic [3:0]  tf_head;
   logic [7:0]  tf_sector_hi;
   logic [7:0]  tf_cyl_low_hi;
   logic [7:0]  tf_cyl_high_hi;
   logic        command_aborted_flag;
   logic        status_err;
   logic [47:0] native_lba;
   logic [31:0] geometry;
   logic        unit_disable;
   logic [1:0]  int_status;
   logic [1:0]  int_mask;

   nmar_pkg::nmar_state_t state;
   nmar_pkg::nmar_query_t query;
   logic [1:0]            exec_cnt;
   logic                  ext_latched;
   logic                  cmd_write;
   nmar_pkg::nmar_query_t next_query;

   nmar_result_if res ();

   nmar_format u_format (
      .ext_form     (ext_latched),
      .lba_mode     (dev_head[`NMAR_DH_LBA_BIT]),
      .native_lba   (native_lba),
      .chs_sector   (geometry[7:0]),
      .chs_cylinder (geometry[23:8]),
      .chs_head     (geometry[27:24]),
      .res          (res)
   );

   // AXI write: address and data accepted independently, response after both
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
   assign s_axi_bresp   = 2'h0;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // software configuration registers; only low byte lane is meaningful for task-file bytes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dev_head          <= `NMAR_DH_RESET;
         upper_half_select <= 1'b0;
         native_lba        <= `NMAR_NATIVE_RESET;
         geometry          <= `NMAR_GEOM_RESET;
         unit_disable      <= 1'b0;
         int_mask          <= 2'h0;
      end else if (wr_fire) begin
         if (aw_addr == `NMAR_OFF_DEVHEAD && w_strb[0]) begin
            dev_head <= w_data[7:0];
         end else if (aw_addr == `NMAR_OFF_DEVCTL && w_strb[0]) begin
            upper_half_select <= w_data[`NMAR_DC_UPPER_BIT];
         end else if (aw_addr == `NMAR_OFF_NATIVE_LO && (&w_strb)) begin
            native_lba[31:0] <= w_data;
         end else if (aw_addr == `NMAR_OFF_NATIVE_HI && (&w_strb[1:0])) begin
            native_lba[47:32] <= w_data[15:0];
         end else if (aw_addr == `NMAR_OFF_GEOMETRY && (&w_strb)) begin
            geometry <= w_data;
         end else if (aw_addr == `NMAR_OFF_CTRL && w_strb[0]) begin
            unit_disable <= w_data[0];
         end else if (aw_addr == `NMAR_OFF_INT_MASK && w_strb[0]) begin
            int_mask <= w_data[1:0];
         end
      end
   end

   // command decode
   assign cmd_write = wr_fire && aw_addr == `NMAR_OFF_COMMAND && w_strb[0]
                      && state == nmar_pkg::NMAR_IDLE;

   always_comb begin
      next_query = nmar_pkg::NMAR_Q_NONE;
      if (w_data[7:0] == `NMAR_CMD_NATIVE) begin
         next_query = nmar_pkg::NMAR_Q_28;
      end else if (w_data[7:0] == `NMAR_CMD_NATIVE_EXT) begin
         next_query = nmar_pkg::NMAR_Q_48;
      end
      // disabled unit cannot execute either query
      if (unit_disable && next_query != nmar_pkg::NMAR_Q_NONE) begin
         next_query = nmar_pkg::NMAR_Q_BAD;
      end
   end

   // busy lasts a fixed number of cycles, then the result is latched
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state       <= nmar_pkg::NMAR_IDLE;
         query       <= nmar_pkg::NMAR_Q_NONE;
         exec_cnt    <= 2'h0;
         ext_latched <= 1'b0;
      end else begin
         case (state)
            nmar_pkg::NMAR_IDLE: begin
               if (cmd_write && next_query != nmar_pkg::NMAR_Q_NONE) begin
                  state       <= nmar_pkg::NMAR_BUSY;
                  query       <= next_query;
                  ext_latched <= (next_query == nmar_pkg::NMAR_Q_48);
                  exec_cnt    <= 2'(`NMAR_EXEC_CYCLES - 1);
               end
            end
            nmar_pkg::NMAR_BUSY: begin
               if (exec_cnt == 2'h0) begin
                  state <= nmar_pkg::NMAR_DONE;
               end else begin
                  exec_cnt <= exec_cnt - 2'h1;
               end
            end
            default: begin
               state <= nmar_pkg::NMAR_IDLE;
            end
         endcase
      end
   end

   // result registers; native source is independent of any host maximum
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tf_sector      <= 8'h00;
         tf_cyl_low     <= 8'h00;
         tf_cyl_high    <= 8'h00;
         tf_head        <= 4'h0;
         tf_sector_hi   <= 8'h00;
         tf_cyl_low_hi  <= 8'h00;
         tf_cyl_high_hi <= 8'h00;
      end else if (state == nmar_pkg::NMAR_DONE && query != nmar_pkg::NMAR_Q_BAD) begin
         tf_sector      <= res.sector;  // R1 R7
         tf_cyl_low     <= res.cyl_low;
         tf_cyl_high    <= res.cyl_high;
         tf_head        <= res.head;
         tf_sector_hi   <= res.sector_hi;
         tf_cyl_low_hi  <= res.cyl_low_hi;
         tf_cyl_high_hi <= res.cyl_high_hi;
      end
   end

   // error state: each new command clears, a failed one sets abort plus error
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         command_aborted_flag <= 1'b0;
         status_err           <= 1'b0;
      end else if (state == nmar_pkg::NMAR_DONE) begin
         command_aborted_flag <= (query == nmar_pkg::NMAR_Q_BAD);  // R11
         status_err           <= (query == nmar_pkg::NMAR_Q_BAD);  // R11
      end else if (cmd_write) begin
         command_aborted_flag <= 1'b0;
         status_err           <= 1'b0;
      end
   end

   // read channel: one outstanding read, answered one cycle after acceptance
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;
   assign rd_addr       = s_axi_araddr;
   assign s_axi_rresp   = 2'h0;

   logic [31:0] rd_value;
   logic        rd_hit;
   logic        rd_is_status;

   always_comb begin
      rd_value     = 32'h00000000;
      rd_hit       = 1'b1;
      rd_is_status = 1'b0;
      if (rd_addr == `NMAR_OFF_DEVHEAD) begin
         rd_value = {24'h000000, dev_head[7:4], tf_head};  // R5 R6
      end else if (rd_addr == `NMAR_OFF_DEVCTL) begin
         rd_value = {24'h000000, upper_half_select, 7'h00};
      end else if (rd_addr == `NMAR_OFF_SECTOR) begin
         rd_value = {24'h000000, upper_half_select ? tf_sector_hi : tf_sector};  // R8
      end else if (rd_addr == `NMAR_OFF_CYL_LOW) begin
         rd_value = {24'h000000, upper_half_select ? tf_cyl_low_hi : tf_cyl_low};  // R9
      end else if (rd_addr == `NMAR_OFF_CYL_HIGH) begin
         rd_value = {24'h000000, upper_half_select ? tf_cyl_high_hi : tf_cyl_high};  // R10
      end else if (rd_addr == `NMAR_OFF_ERROR) begin
         rd_value = {29'h00000000, command_aborted_flag, 2'h0};  // R11
      end else if (rd_addr == `NMAR_OFF_STATUS) begin
         // busy set until back in idle, including the done cycle; ready and seek complete set when idle
         rd_value[`NMAR_ST_BUSY_BIT]  = (state != nmar_pkg::NMAR_IDLE);
         rd_value[`NMAR_ST_READY_BIT] = (state == nmar_pkg::NMAR_IDLE);
         rd_value[`NMAR_ST_SEEK_BIT]  = (state == nmar_pkg::NMAR_IDLE);
         rd_value[`NMAR_ST_ERR_BIT]   = status_err;
      end else if (rd_addr == `NMAR_OFF_NATIVE_LO) begin
         rd_value = native_lba[31:0];
      end else if (rd_addr == `NMAR_OFF_NATIVE_HI) begin
         rd_value = {16'h0000, native_lba[47:32]};
      end else if (rd_addr == `NMAR_OFF_GEOMETRY) begin
         rd_value = geometry;
      end else if (rd_addr == `NMAR_OFF_CTRL) begin
         rd_value = {31'h00000000, unit_disable};
      end else if (rd_addr == `NMAR_OFF_INT_STATUS) begin
         rd_value = {30'h00000000, int_status};
         rd_is_status = 1'b1;
      end else if (rd_addr == `NMAR_OFF_INT_MASK) begin
         rd_value = {30'h00000000, int_mask};
      end else if (rd_addr == `NMAR_OFF_COMMAND) begin
         rd_value = 32'h00000000;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_value;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // interrupt status: bit0 query done, bit1 query aborted; read clears, set wins
   logic [1:0] int_set;
   assign int_set = (state == nmar_pkg::NMAR_DONE)
                    ? {query == nmar_pkg::NMAR_Q_BAD, 1'b1} : 2'h0;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_status <= 2'h0;
      end else if (rd_fire && rd_is_status && rd_hit) begin
         int_status <= int_set;
      end else begin
         int_status <= int_status | int_set;
      end
   end

   assign irq = |(int_status & int_mask);
endmodule // nmar_top

// ==== sim/nmar_top_props.sv ====
// Purpose: bus handshake checks at the ports of nmar_top
// Assumes: single clock, rstn async active low
// Notes: bound below; sees only top-level ports
`timescale 1ns/1ps
module nmar_props (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   // both halves held one edge after acceptance, response raised on the next
   a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_resp_okay: assert property (s_axi_bvalid || s_axi_rvalid |->
      s_axi_bresp == 2'b00 && s_axi_rresp == 2'b00)
      else $error("response code not okay");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_irq: cover property ($rose(irq));
endmodule // nmar_props

bind nmar_top nmar_props i_props (.clk, .rstn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .irq);

// ==== sim/nmar_host.sv ====
// Purpose: host controller model issuing task-file accesses over AXI4-Lite
// Assumes: single clock; one access at a time
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module nmar_host (
   input  wire logic        clk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   output logic             s_axi_rready,
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wready,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_arready,
   input  wire logic        s_axi_rvalid,
   input  wire logic [31:0] s_axi_rdata
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
endmodule // nmar_host

// ==== sim/nmar_top_tb_top.sv ====
// Purpose: self-checking bench for the native max address queries
// Assumes: host model drives the register bus
// Notes: native values are loaded through registers before each query except the aborted one
`timescale 1ns/1ps
`include "nmar_map.svh"
module nmar_top_tb_top;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, irq;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   always #5 clk = ~clk;
   nmar_top i_dut (.*);
   nmar_host i_host (.*);
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // run is short; a stuck handshake ends here
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         $display("[ERR] %0t timeout", $time);
         summarize;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      i_host.rd(a, v);
      chk(v & m, e);
   endtask
   task automatic run(input logic [7:0] c);
      int n;
      logic [31:0] v;
      n = 0;
      i_host.wr(`NMAR_OFF_COMMAND, {24'h0, c});
      do begin
         i_host.rd(`NMAR_OFF_STATUS, v);
         n++;
      end while (v[7] !== 1'b0 && n < 20);
      chk({31'h0, v[7]}, 32'h0);
   endtask
   // expected {cylinder high, cylinder low, sector}
   task automatic trio(input logic [23:0] e);
      rdc(`NMAR_OFF_SECTOR, 32'hFF, {24'h0, e[7:0]});
      rdc(`NMAR_OFF_CYL_LOW, 32'hFF, {24'h0, e[15:8]});
      rdc(`NMAR_OFF_CYL_HIGH, 32'hFF, {24'h0, e[23:16]});
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rdc(`NMAR_OFF_DEVHEAD, 32'hFF, 32'hA0);
      rdc(8'hFC, 32'hFFFFFFFF, 32'h0);
      $display("test reset done");
      i_host.wr(`NMAR_OFF_NATIVE_LO, 32'h0ABCDEF5);
      i_host.wr(`NMAR_OFF_NATIVE_HI, 32'h0);
      i_host.wr(`NMAR_OFF_DEVHEAD, 32'hE0);
      run(`NMAR_CMD_NATIVE);
      trio(24'hBCDEF5);
      rdc(`NMAR_OFF_DEVHEAD, 32'h0F, 32'hA);
      chk({31'h0, irq}, 32'h0);
      $display("test lba28 done");
      // smallest native value past the 28-bit range
      i_host.wr(`NMAR_OFF_NATIVE_LO, 32'h10000000);
      run(`NMAR_CMD_NATIVE);
      trio(24'hFFFFFF);
      rdc(`NMAR_OFF_DEVHEAD, 32'h0F, 32'hF);
      $display("test clamp done");
      i_host.wr(`NMAR_OFF_NATIVE_HI, 32'h1234);
      i_host.wr(`NMAR_OFF_NATIVE_LO, 32'h89ABCDEF);
      run(`NMAR_CMD_NATIVE_EXT);
      trio(24'hABCDEF);
      i_host.wr(`NMAR_OFF_DEVCTL, 32'h80);
      trio(24'h123489);
      i_host.wr(`NMAR_OFF_DEVCTL, 32'h0);
      $display("test ext done");
      i_host.wr(`NMAR_OFF_DEVHEAD, 32'hA0);
      i_host.wr(`NMAR_OFF_GEOMETRY, 32'h0512343F);
      run(`NMAR_CMD_NATIVE);
      trio(24'h12343F);
      rdc(`NMAR_OFF_DEVHEAD, 32'h0F, 32'h5);
      $display("test chs done");
      // clear pending done events before unmasking
      rdc(`NMAR_OFF_INT_STATUS, 32'h3, 32'h1);
      i_host.wr(`NMAR_OFF_INT_MASK, 32'h3);
      i_host.wr(`NMAR_OFF_CTRL, 32'h1);
      run(`NMAR_CMD_NATIVE_EXT);
      rdc(`NMAR_OFF_ERROR, 32'hFF, 32'h04);
      rdc(`NMAR_OFF_STATUS, 32'hA1, 32'h01);
      trio(24'h12343F);
      chk({31'h0, irq}, 32'h1);
      rdc(`NMAR_OFF_INT_STATUS, 32'h2, 32'h2);
      chk({31'h0, irq}, 32'h0);
      $display("test abort done");
      // a code that is neither query must start nothing and raise no event
      i_host.wr(`NMAR_OFF_COMMAND, 32'h00000055);
      rdc(`NMAR_OFF_STATUS, 32'h80, 32'h0);
      rdc(`NMAR_OFF_INT_STATUS, 32'h3, 32'h0);
      $display("test ignored code done");
      summarize;
   end
endmodule // nmar_top_tb_top
